// ### rtl/cbsc_defines.vh
// Constants for the card bridge system control middle field block
`ifndef CBSC_DEFINES_VH
`define CBSC_DEFINES_VH

// ------------------------------------------------------------
// Register byte addresses (socket 0 and socket 1 copies, plus shared interrupt status and mask)
// ------------------------------------------------------------
`define CBSC_ADDR_SYSCTL0 8'h80
`define CBSC_ADDR_SYSCTL1 8'h84
`define CBSC_ADDR_IRQ_STATUS 8'h88
`define CBSC_ADDR_IRQ_MASK 8'h8c
`define CBSC_ADDR_POWER_CMD0 8'h90
`define CBSC_ADDR_POWER_CMD1 8'h94

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CBSC_BIT_RSVD_DRIVE 22
`define CBSC_BIT_SUPPLY_OFF 21
`define CBSC_BIT_ZV_REDUCED 20
`define CBSC_BIT_DMA_REQ_EN 19
`define CBSC_CHAN_HI 18
`define CBSC_CHAN_LO 16
`define CBSC_BIT_BURST_DN 15
`define CBSC_BIT_BURST_UP 14
`define CBSC_BIT_ACTIVITY 13
`define CBSC_BIT_RAIL 12
`define CBSC_BIT_STREAM 11
`define CBSC_BIT_UP_WAIT 10
`define CBSC_BIT_DOWN_WAIT 9
`define CBSC_BIT_PROBE 8
`define CBSC_BIT_RSVD7 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CBSC_CHAN_RESET 3'h4
`define CBSC_CHAN_PCI_MASTER 3'h4
`define CBSC_BURST_DN_RESET 1'b1
`define CBSC_BURST_UP_RESET 1'b0

// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define CBSC_IRQ_W 4
`define CBSC_IRQ_ACT0 0
`define CBSC_IRQ_ACT1 1
`define CBSC_IRQ_PWR0 2
`define CBSC_IRQ_PWR1 3

// ------------------------------------------------------------
// Power sequencing
// ------------------------------------------------------------
`define CBSC_STREAM_BITS 16
`define CBSC_CLK_HZ 20000000
`define CBSC_HZ_PER_MHZ 1000000
`define CBSC_BIT_PWR_UP 31
`define CBSC_UP_DELAY_US 50
`define CBSC_DOWN_DELAY_US 50
`define CBSC_CNT_W 20
`define CBSC_HTRANS_NONSEQ 2'b10

`endif

// ### rtl/cbsc_power_seq.v
// Power switch serial stream and settling delay sequencer for one socket
`timescale 1ns/100ps
`include "cbsc_defines.vh"

module cbsc_power_seq #(
  parameter STREAM_BITS = `CBSC_STREAM_BITS,
  parameter [`CBSC_CNT_W-1:0] UP_CYCLES = 20'd1000,
  parameter [`CBSC_CNT_W-1:0] DOWN_CYCLES = 20'd1000
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire power_up,
  input wire [STREAM_BITS-1:0] stream_word,
  output reg switch_data,
  output reg switch_latch,
  output wire stream_busy,
  output wire up_wait,
  output wire down_wait,
  output reg done
);

// ------------------------------------------------------------
// States
// ------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_SHIFT = 2'd1;
localparam [1:0] ST_DELAY = 2'd2;
localparam integer LAST_BIT = STREAM_BITS - 1;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [STREAM_BITS-1:0] shift_reg;
reg [`CBSC_CNT_W-1:0] count_reg;
reg up_reg;

assign stream_busy = (state_reg != ST_IDLE);
assign up_wait = (state_reg == ST_DELAY) && up_reg;
assign down_wait = (state_reg == ST_DELAY) && !up_reg;

always @* begin
  state_next = state_reg;
  case (state_reg)
    ST_IDLE: begin
      if (start) begin
        state_next = ST_SHIFT;
      end
    end
    ST_SHIFT: begin
      if (count_reg == {`CBSC_CNT_W{1'b0}}) begin
        state_next = ST_DELAY;
      end
    end
    ST_DELAY: begin
      if (count_reg == {`CBSC_CNT_W{1'b0}}) begin
        state_next = ST_IDLE;
      end
    end
    default: begin
      state_next = ST_IDLE;
    end
  endcase
end

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    state_reg <= ST_IDLE;
    shift_reg <= {STREAM_BITS{1'b0}};
    count_reg <= {`CBSC_CNT_W{1'b0}};
    up_reg <= 1'b0;
    switch_data <= 1'b0;
    switch_latch <= 1'b0;
    done <= 1'b0;
  end else begin
    state_reg <= state_next;
    switch_latch <= 1'b0;
    done <= 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          shift_reg <= stream_word;
          up_reg <= power_up;
          count_reg <= LAST_BIT[`CBSC_CNT_W-1:0];
        end
      end
      ST_SHIFT: begin
        switch_data <= shift_reg[STREAM_BITS-1];
        shift_reg <= {shift_reg[STREAM_BITS-2:0], 1'b0};
        if (count_reg == {`CBSC_CNT_W{1'b0}}) begin
          switch_latch <= 1'b1;
          count_reg <= up_reg ? UP_CYCLES : DOWN_CYCLES;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
      ST_DELAY: begin
        if (count_reg == {`CBSC_CNT_W{1'b0}}) begin
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
      default: begin
        count_reg <= {`CBSC_CNT_W{1'b0}};
      end
    endcase
  end
end

endmodule // cbsc_power_seq

// ### rtl/cbsc_system_control.v
// AHB-Lite system control middle fields for a two-socket card bridge
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "cbsc_defines.vh"

module cbsc_system_control #(
  parameter SOCKETS = 2,
  parameter STREAM_BITS = `CBSC_STREAM_BITS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire irq,
  input wire [1:0] card_present,
  input wire [1:0] card_is_cardbus,
  input wire [1:0] card_access,
  input wire [1:0] card_probe_active,
  input wire [1:0] card_dma_request_line,
  output wire [1:0] rsvd_term_out,
  output wire [1:0] rsvd_term_oe,
  output wire [1:0] supply_protect_en,
  output wire [1:0] card_addr_hi_oe,
  output wire [1:0] dma_request,
  output wire [5:0] dma_channel,
  output wire [1:0] dma_channel_16bit,
  output wire burst_downstream_allow,
  output wire burst_upstream_allow,
  output wire [1:0] power_switch_data,
  output wire [1:0] power_switch_latch
);

localparam integer UP_TOTAL =
  (`CBSC_CLK_HZ / `CBSC_HZ_PER_MHZ) * `CBSC_UP_DELAY_US;
localparam integer DOWN_TOTAL =
  (`CBSC_CLK_HZ / `CBSC_HZ_PER_MHZ) * `CBSC_DOWN_DELAY_US;
localparam [`CBSC_CNT_W-1:0] UP_CYCLES = UP_TOTAL[`CBSC_CNT_W-1:0];
localparam [`CBSC_CNT_W-1:0] DOWN_CYCLES = DOWN_TOTAL[`CBSC_CNT_W-1:0];

// ------------------------------------------------------------
// Address decode helpers
// ------------------------------------------------------------
function addr_is;
  input [7:0] a;
  input [7:0] target;
  begin
    addr_is = (a == target);
  end
endfunction

// ------------------------------------------------------------
// Input synchronisers
// ------------------------------------------------------------
reg [9:0] sync1_reg;
reg [9:0] sync2_reg;
wire [9:0] pin_in;
assign pin_in = {card_present, card_is_cardbus, card_access,
                 card_probe_active, card_dma_request_line};

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    sync1_reg <= 10'h000;
    sync2_reg <= 10'h000;
  end else begin
    sync1_reg <= pin_in;
    sync2_reg <= sync1_reg;
  end
end

wire [1:0] present_s;
wire [1:0] cardbus_s;
wire [1:0] access_s;
wire [1:0] probe_s;
wire [1:0] card_dma_request_line_s;
assign present_s = sync2_reg[9:8];
assign cardbus_s = sync2_reg[7:6];
assign access_s = sync2_reg[5:4];
assign probe_s = sync2_reg[3:2];
assign card_dma_request_line_s = sync2_reg[1:0];

// ------------------------------------------------------------
// AHB-Lite address phase capture
// ------------------------------------------------------------
reg wr_pend_reg;
reg [7:0] addr_reg;
reg [31:0] rdata_reg;
wire access_ok;
wire rd_now;
assign access_ok = hsel && hready && (htrans == `CBSC_HTRANS_NONSEQ);
assign rd_now = access_ok && !hwrite;
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_reg;

// ------------------------------------------------------------
// Writable fields
// ------------------------------------------------------------
reg [1:0] rsvd_drive_reg;
reg [1:0] supply_off_reg;
reg [1:0] zv_reduced_reg;
reg [1:0] dma_en_reg;
reg [5:0] chan_reg;
reg burst_dn_reg;
reg burst_up_reg;
reg [1:0] activity_reg;
reg [1:0] start_reg;
reg [1:0] up_sel_reg;
reg [STREAM_BITS-1:0] word0_reg;
reg [STREAM_BITS-1:0] word1_reg;
reg [`CBSC_IRQ_W-1:0] irq_stat_reg;
reg [`CBSC_IRQ_W-1:0] irq_mask_reg;

wire [1:0] stream_busy;
wire [1:0] up_wait;
wire [1:0] down_wait;
wire [1:0] pwr_done;

wire wr_ctl0;
wire wr_ctl1;
assign wr_ctl0 = wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_SYSCTL0);
assign wr_ctl1 = wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_SYSCTL1);

// Read of socket activity bit clears it
wire [1:0] act_rd;
assign act_rd[0] = rd_now && addr_is(haddr[7:0], `CBSC_ADDR_SYSCTL0);
assign act_rd[1] = rd_now && addr_is(haddr[7:0], `CBSC_ADDR_SYSCTL1);

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    wr_pend_reg <= 1'b0;
    addr_reg <= 8'h00;
    rsvd_drive_reg <= 2'b00;
    supply_off_reg <= 2'b00;
    zv_reduced_reg <= 2'b00;
    dma_en_reg <= 2'b00;
    chan_reg <= {`CBSC_CHAN_RESET, `CBSC_CHAN_RESET};
    burst_dn_reg <= `CBSC_BURST_DN_RESET;
    burst_up_reg <= `CBSC_BURST_UP_RESET;
    activity_reg <= 2'b00;
    start_reg <= 2'b00;
    up_sel_reg <= 2'b00;
    word0_reg <= {STREAM_BITS{1'b0}};
    word1_reg <= {STREAM_BITS{1'b0}};
    irq_stat_reg <= {`CBSC_IRQ_W{1'b0}};
    irq_mask_reg <= {`CBSC_IRQ_W{1'b0}};
  end else begin
    wr_pend_reg <= access_ok && hwrite;
    if (access_ok) begin
      addr_reg <= haddr[7:0];
    end
    start_reg <= 2'b00;
    // Set wins over read clear
    activity_reg <= (activity_reg & ~act_rd) | access_s;
    if (wr_ctl0) begin
      rsvd_drive_reg[0] <= hwdata[`CBSC_BIT_RSVD_DRIVE];
      supply_off_reg[0] <= hwdata[`CBSC_BIT_SUPPLY_OFF];
      zv_reduced_reg[0] <= hwdata[`CBSC_BIT_ZV_REDUCED];
      dma_en_reg[0] <= hwdata[`CBSC_BIT_DMA_REQ_EN];
      chan_reg[2:0] <= hwdata[`CBSC_CHAN_HI:`CBSC_CHAN_LO];
      burst_dn_reg <= hwdata[`CBSC_BIT_BURST_DN];
      burst_up_reg <= hwdata[`CBSC_BIT_BURST_UP];
    end
    if (wr_ctl1) begin
      rsvd_drive_reg[1] <= hwdata[`CBSC_BIT_RSVD_DRIVE];
      supply_off_reg[1] <= hwdata[`CBSC_BIT_SUPPLY_OFF];
      zv_reduced_reg[1] <= hwdata[`CBSC_BIT_ZV_REDUCED];
      dma_en_reg[1] <= hwdata[`CBSC_BIT_DMA_REQ_EN];
      chan_reg[5:3] <= hwdata[`CBSC_CHAN_HI:`CBSC_CHAN_LO];
    end
    if (wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_POWER_CMD0) &&
        !stream_busy[0]) begin
      word0_reg <= hwdata[STREAM_BITS-1:0];
      up_sel_reg[0] <= hwdata[`CBSC_BIT_PWR_UP];
      start_reg[0] <= 1'b1;
    end
    if (wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_POWER_CMD1) &&
        !stream_busy[1]) begin
      word1_reg <= hwdata[STREAM_BITS-1:0];
      up_sel_reg[1] <= hwdata[`CBSC_BIT_PWR_UP];
      start_reg[1] <= 1'b1;
    end
    if (wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_IRQ_MASK)) begin
      irq_mask_reg <= hwdata[`CBSC_IRQ_W-1:0];
    end
    // Write-one clear, events set afterwards so they win
    irq_stat_reg <= (irq_stat_reg &
      ~((wr_pend_reg && addr_is(addr_reg, `CBSC_ADDR_IRQ_STATUS)) ?
        hwdata[`CBSC_IRQ_W-1:0] : {`CBSC_IRQ_W{1'b0}})) |
      {pwr_done[1], pwr_done[0], access_s[1], access_s[0]};
  end
end

assign irq = |(irq_stat_reg & irq_mask_reg);

// ------------------------------------------------------------
// Power switch sequencers, one per socket
// ------------------------------------------------------------
genvar gi;
generate
  for (gi = 0; gi < SOCKETS; gi = gi + 1) begin : g_pwr
    cbsc_power_seq #(
      .STREAM_BITS(STREAM_BITS),
      .UP_CYCLES(UP_CYCLES),
      .DOWN_CYCLES(DOWN_CYCLES)
    ) u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(start_reg[gi]),
      .power_up(up_sel_reg[gi]),
      .stream_word(gi == 0 ? word0_reg : word1_reg),
      .switch_data(power_switch_data[gi]),
      .switch_latch(power_switch_latch[gi]),
      .stream_busy(stream_busy[gi]),
      .up_wait(up_wait[gi]),
      .down_wait(down_wait[gi]),
      .done(pwr_done[gi])
    );
    assign rsvd_term_out[gi] = 1'b0;
    assign rsvd_term_oe[gi] = rsvd_drive_reg[gi] && present_s[gi] &&
                              cardbus_s[gi];
    assign supply_protect_en[gi] = !supply_off_reg[gi];
    assign card_addr_hi_oe[gi] = !zv_reduced_reg[gi];
    assign dma_request[gi] = dma_en_reg[gi] && card_dma_request_line_s[gi];
    assign dma_channel_16bit[gi] =
      chan_reg[gi*3+2] && (chan_reg[gi*3+2 -: 3] != `CBSC_CHAN_PCI_MASTER);
  end
endgenerate

assign dma_channel = chan_reg;
assign burst_downstream_allow = burst_dn_reg;
assign burst_upstream_allow = burst_up_reg;

// ------------------------------------------------------------
// Read data
// ------------------------------------------------------------
// Every field except the fixed rail and bit 7 is an argument, so the read mux sees each change
function [31:0] sysctl_word;
  input [3:0] ctl;
  input [2:0] chan;
  input [1:0] burst;
  input [4:0] stat;
  begin
    sysctl_word = 32'h0000_0000;
    sysctl_word[`CBSC_BIT_RSVD_DRIVE] = ctl[3];
    sysctl_word[`CBSC_BIT_SUPPLY_OFF] = ctl[2];
    sysctl_word[`CBSC_BIT_ZV_REDUCED] = ctl[1];
    sysctl_word[`CBSC_BIT_DMA_REQ_EN] = ctl[0];
    sysctl_word[`CBSC_CHAN_HI:`CBSC_CHAN_LO] = chan;
    // Burst bits are global, shared by both sockets; the status bits below are per socket except the rail bit, fixed at 1
    sysctl_word[`CBSC_BIT_BURST_DN] = burst[1];
    sysctl_word[`CBSC_BIT_BURST_UP] = burst[0];
    sysctl_word[`CBSC_BIT_ACTIVITY] = stat[4];
    sysctl_word[`CBSC_BIT_RAIL] = 1'b1;
    sysctl_word[`CBSC_BIT_STREAM] = stat[3];
    sysctl_word[`CBSC_BIT_UP_WAIT] = stat[2];
    sysctl_word[`CBSC_BIT_DOWN_WAIT] = stat[1];
    sysctl_word[`CBSC_BIT_PROBE] = stat[0];
    sysctl_word[`CBSC_BIT_RSVD7] = 1'b0;
  end
endfunction

reg [31:0] rdata_next;
always @* begin
  rdata_next = 32'h0000_0000;
  case (haddr[7:0])
    `CBSC_ADDR_SYSCTL0: rdata_next = sysctl_word({rsvd_drive_reg[0],
      supply_off_reg[0], zv_reduced_reg[0], dma_en_reg[0]}, chan_reg[2:0],
      {burst_dn_reg, burst_up_reg}, {activity_reg[0], stream_busy[0],
      up_wait[0], down_wait[0], probe_s[0]});
    `CBSC_ADDR_SYSCTL1: rdata_next = sysctl_word({rsvd_drive_reg[1],
      supply_off_reg[1], zv_reduced_reg[1], dma_en_reg[1]}, chan_reg[5:3],
      {burst_dn_reg, burst_up_reg}, {activity_reg[1], stream_busy[1],
      up_wait[1], down_wait[1], probe_s[1]});
    `CBSC_ADDR_IRQ_STATUS: rdata_next[`CBSC_IRQ_W-1:0] = irq_stat_reg;
    `CBSC_ADDR_IRQ_MASK: rdata_next[`CBSC_IRQ_W-1:0] = irq_mask_reg;
    `CBSC_ADDR_POWER_CMD0: rdata_next[0] = stream_busy[0];
    `CBSC_ADDR_POWER_CMD1: rdata_next[0] = stream_busy[1];
    default: rdata_next = 32'h0000_0000;
  endcase
end

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    rdata_reg <= 32'h0000_0000;
  end else if (rd_now) begin
    rdata_reg <= rdata_next;
  end
end

endmodule // cbsc_system_control

// ### dv/cbsc_system_control_properties.sv
// Concurrent checks on the system control register block ports
`timescale 1ns/100ps
module cbsc_system_control_properties (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [1:0] card_dma_request_line,
  input wire [1:0] rsvd_term_out,
  input wire [1:0] supply_protect_en,
  input wire [1:0] card_addr_hi_oe,
  input wire [1:0] dma_request,
  input wire [5:0] dma_channel,
  input wire [1:0] dma_channel_16bit,
  input wire burst_downstream_allow,
  input wire burst_upstream_allow,
  input wire [1:0] power_switch_latch
);
  // ----------------------------------------
  // Data phase tracking
  // ----------------------------------------
  wire take = hsel & hready & (htrans == 2'b10);
  reg wr_sys0_reg, rd_sys_reg, wr_pwr0_reg;
  reg [31:0] hwdata_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sys0_reg <= 1'b0;
      rd_sys_reg <= 1'b0;
      wr_pwr0_reg <= 1'b0;
      hwdata_reg <= 32'h0000_0000;
    end else begin
      wr_sys0_reg <= take & hwrite & (haddr[7:0] == 8'h80);
      rd_sys_reg <= take & !hwrite & (haddr[7:3] == 5'h10);
      wr_pwr0_reg <= take & hwrite & (haddr[7:0] == 8'h90);
      hwdata_reg <= hwdata;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence sys0_wr_s;
    wr_sys0_reg;
  endsequence
  sequence pwr0_start_s;
    wr_pwr0_reg ##1 !power_switch_latch[0];
  endsequence

  supply_follow_a: assert property (sys0_wr_s |=>
    supply_protect_en[0] == !hwdata_reg[21]) else $error("supply bit");
  zv_float_a: assert property (sys0_wr_s |=>
    card_addr_hi_oe[0] == !hwdata_reg[20]) else $error("zv bit");
  chan_write_a: assert property (sys0_wr_s |=>
    dma_channel[2:0] == hwdata_reg[18:16]) else $error("channel");
  burst_write_a: assert property (sys0_wr_s |=>
    {burst_downstream_allow, burst_upstream_allow} == hwdata_reg[15:14])
    else $error("burst bits");
  chan_class_a: assert property (dma_channel_16bit ==
    {dma_channel[5:3] > 3'h4, dma_channel[2:0] > 3'h4})
    else $error("channel class");
  card_dma_request_line_gate_a: assert property (dma_request[0] |->
    $past(card_dma_request_line[0], 2)) else $error("dma request");
  rsvd_low_a: assert property (rsvd_term_out == 2'b00 &&
    hresp == 1'b0 && hreadyout) else $error("drive level");
  status_bits_a: assert property (rd_sys_reg |->
    hrdata[12] && !hrdata[7]) else $error("fixed bits");
  reset_vals_a: assert property ($rose(hresetn) |->
    dma_channel == 6'h24 && burst_downstream_allow &&
    !burst_upstream_allow) else $error("reset values");
  stream_len_a: assert property (pwr0_start_s |->
    ##[12:24] power_switch_latch[0]) else $error("stream length");
  latch_pulse_a: assert property (power_switch_latch[0] |=>
    !power_switch_latch[0]) else $error("latch pulse");
endmodule // cbsc_system_control_properties

bind cbsc_system_control cbsc_system_control_properties
  cbsc_system_control_properties_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .card_dma_request_line(card_dma_request_line),
  .rsvd_term_out(rsvd_term_out), .supply_protect_en(supply_protect_en),
  .card_addr_hi_oe(card_addr_hi_oe), .dma_request(dma_request),
  .dma_channel(dma_channel), .dma_channel_16bit(dma_channel_16bit),
  .burst_downstream_allow(burst_downstream_allow),
  .burst_upstream_allow(burst_upstream_allow),
  .power_switch_latch(power_switch_latch));

// ### dv/cbsc_system_control_tb.sv
// Self-checking testbench for the system control register block
`timescale 1ns/100ps
module cbsc_system_control_tb;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0, card_present = 0, card_is_cardbus = 0;
  reg [1:0] card_access = 0, card_probe_active = 0;
  reg [1:0] card_dma_request_line = 0;
  reg [2:0] hsize = 3'h2;
  reg [15:0] sr;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  wire hready = hreadyout;
  wire [1:0] rsvd_term_out, rsvd_term_oe, supply_protect_en;
  wire [1:0] card_addr_hi_oe, dma_request, dma_channel_16bit;
  wire [1:0] power_switch_data, power_switch_latch;
  wire [5:0] dma_channel;
  wire burst_downstream_allow, burst_upstream_allow;
  integer miscompares = 0, compares = 0, i, n;

  always #25 hclk = ~hclk;

  cbsc_system_control cbsc_system_control_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .card_present(card_present), .card_is_cardbus(card_is_cardbus),
    .card_access(card_access), .card_probe_active(card_probe_active),
    .card_dma_request_line(card_dma_request_line),
    .rsvd_term_out(rsvd_term_out), .rsvd_term_oe(rsvd_term_oe),
    .supply_protect_en(supply_protect_en),
    .card_addr_hi_oe(card_addr_hi_oe), .dma_request(dma_request),
    .dma_channel(dma_channel), .dma_channel_16bit(dma_channel_16bit),
    .burst_downstream_allow(burst_downstream_allow),
    .burst_upstream_allow(burst_upstream_allow),
    .power_switch_data(power_switch_data),
    .power_switch_latch(power_switch_latch));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task check(input string nm, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task xfer(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rc(input string nm, input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0000_0000);
      check(nm, rd, e);
    end
  endtask

  task idle(input integer k);
    begin
      repeat (k) @(posedge hclk);
      #1;
    end
  endtask

  task finish_test;
    begin
      if (miscompares == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    begin
      rc("sys0", 8'h80, 32'h0004_9000);
      rc("sys1", 8'h84, 32'h0004_9000);
      check("pins", {supply_protect_en, card_addr_hi_oe, dma_channel,
        burst_downstream_allow, burst_upstream_allow, rsvd_term_oe, irq},
        32'h0000_7C90);
    end
  endtask

  task t_fields;
    begin
      wr(8'h80, 32'h007F_FF80);
      rc("sys0w", 8'h80, 32'h007F_D000);
      check("pins0", {supply_protect_en[0], card_addr_hi_oe[0],
        dma_channel[2:0], dma_channel_16bit[0], burst_downstream_allow,
        burst_upstream_allow}, 32'h0000_003F);
      for (i = 0; i < 8; i = i + 1) begin
        wr(8'h84, i << 16);
        idle(1);
        check("chan", {dma_channel[5:3], dma_channel_16bit[1]},
          {i[2:0], i > 4});
      end
      check("glob", {burst_downstream_allow, burst_upstream_allow},
        2'b11);
    end
  endtask

  task t_pins;
    begin
      @(posedge hclk);
      card_present <= 2'b11;
      card_is_cardbus <= 2'b11;
      card_dma_request_line <= 2'b11;
      idle(4);
      check("rsvd", rsvd_term_oe, 2'b01);
      check("card_dma_request_line", dma_request, 2'b01);
      @(posedge hclk);
      card_is_cardbus <= 2'b10;
      card_dma_request_line <= 2'b00;
      idle(4);
      check("rsvdx", {rsvd_term_oe, dma_request}, 4'h0);
    end
  endtask

  task t_act;
    begin
      @(posedge hclk);
      card_access <= 2'b10;
      @(posedge hclk);
      card_access <= 2'b00;
      idle(4);
      rc("act", 8'h84, 32'h0007_F000);
      rc("actc", 8'h84, 32'h0007_D000);
      wr(8'h8C, 32'h0000_0000);
      idle(1);
      check("irqm", irq, 1'b0);
      wr(8'h8C, 32'h0000_0002);
      idle(1);
      check("irq", irq, 1'b1);
      wr(8'h88, 32'h0000_0002);
      idle(1);
      check("irqc", irq, 1'b0);
      rc("stat", 8'h88, 32'h0000_0000);
      @(posedge hclk);
      card_probe_active <= 2'b01;
      idle(4);
      rc("prb", 8'h80, 32'h007F_D100);
      @(posedge hclk);
      card_probe_active <= 2'b00;
      idle(4);
      rc("prbx", 8'h80, 32'h007F_D000);
    end
  endtask

  task t_power;
    begin
      wr(8'h90, 32'h8000_A5C3);
      #1;
      n = 0;
      sr = 16'h0000;
      while (power_switch_latch[0] !== 1'b1 && n < 40) begin
        idle(1);
        sr = {sr[14:0], power_switch_data[0]};
        n = n + 1;
      end
      check("strm", sr, 16'hA5C3);
      rc("up", 8'h80, 32'h007F_DC00);
      rc("busy", 8'h90, 32'h0000_0001);
      idle(1100);
      rc("upd", 8'h80, 32'h007F_D000);
      rc("done", 8'h88, 32'h0000_0004);
      wr(8'h90, 32'h0000_0F0F);
      rc("dn0", 8'h80, 32'h007F_D800);
      idle(20);
      rc("dn1", 8'h80, 32'h007F_DA00);
      idle(1100);
      rc("dn2", 8'h80, 32'h007F_D000);
      wr(8'h94, 32'h8000_0001);
      rc("s1up", 8'h84, 32'h0007_D800);
      idle(1100);
      rc("s1dn", 8'h88, 32'h0000_000C);
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_fields;
    t_pins;
    t_act;
    t_power;
    finish_test;
  end

  initial begin
    #500000;
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule // cbsc_system_control_tb
